// [hw/stf_ctrl.sv]
// controller end: formats or verifies one whole track per command
// Operation
// - intersector gap at least sixteen bytes
// - address area fields in fixed order
// - address preamble of eleven zero bytes
// - sync byte FE after each preamble
// - address: cylinder, head, sector, flags
// - write address check, verify on read
// - two zero pad after address check
// - address written only when formatting
// - data area opens with zero splice
// - data preamble eleven zeros, then sync
// - data check bytes appended, never checked; verify mode reads only the address area
// - two zero pad after data check
// - drive clock locked to rotation
// - drive gives index and sector pulses
// - drive reports preamble and gap sizes
// - up to seven drives, shared control
// - write gate held two bytes after
// - drive write turn-on three to seven
`include "stf_defs.svh"
module stf_ctrl #(
   parameter int SECTORS    = `STF_SECTORS,
   parameter int DATA_BYTES = `STF_DATA_BYTES
) (
   stf_link_if.ctrl         lnk,        // link to the drives
   input  wire logic        core_clk,   // core clock, 200 MHz
   input  wire logic        rst,        // async reset, active high
   input  wire logic        clk_en,     // freezes all state while low
   input  wire logic        cmd_valid,  // command offered
   output logic             cmd_ready,  // command taken when high with valid
   input  wire logic        cmd_verify, // 1 verify track, 0 format track
   input  wire logic [2:0]  cmd_drive,  // drive address 1..7
   input  wire logic [15:0] cmd_cyl,    // cylinder
   input  wire logic [7:0]  cmd_head,   // head
   input  wire logic [7:0]  cmd_flags,  // flag byte
   input  wire logic [7:0]  cmd_fill,   // data field fill byte
   output logic             done,       // one-cycle pulse, track finished
   output logic [7:0]       err_count   // sectors whose address check failed
);
   // sector number and byte counter widths bound these
   if (SECTORS < 1 || SECTORS > 255 || DATA_BYTES < 1 || DATA_BYTES > 65535) begin : g_bad_params
      $error("stf_ctrl: bad parameters");
   end

   // ---------------- core side ----------------
   logic        busy_reg;
   logic        req_tgl_reg;
   logic        done_s1_reg;
   logic        done_s2_reg;
   logic        done_seen_reg;
   logic        c_verify_reg;
   logic [2:0]  c_drive_reg;
   logic [15:0] c_cyl_reg;
   logic [7:0]  c_head_reg;
   logic [7:0]  c_flags_reg;
   logic [7:0]  c_fill_reg;
   // link side
   logic        done_tgl_reg;
   logic        req_s1_reg;
   logic        req_s2_reg;
   logic        req_seen_reg;
   logic [7:0]  l_err_reg;

   assign cmd_ready = !busy_reg;

   // command words stay still from the toggle until done returns, so the link may read them freely
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_reg     <= 1'b0;
         req_tgl_reg  <= 1'b0;
         c_verify_reg <= 1'b0;
         c_drive_reg  <= 3'h0;
         c_cyl_reg    <= 16'h0000;
         c_head_reg   <= 8'h00;
         c_flags_reg  <= 8'h00;
         c_fill_reg   <= 8'h00;
      end else if (clk_en) begin
         if (cmd_valid && !busy_reg) begin
            busy_reg     <= 1'b1;
            req_tgl_reg  <= !req_tgl_reg;
            c_verify_reg <= cmd_verify;
            c_drive_reg  <= cmd_drive;
            c_cyl_reg    <= cmd_cyl;
            c_head_reg   <= cmd_head;
            c_flags_reg  <= cmd_flags;
            c_fill_reg   <= cmd_fill;
         end else if (done_s2_reg != done_seen_reg) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // done toggle back from the link, error count is stable once it arrives
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done_s1_reg   <= 1'b0;
         done_s2_reg   <= 1'b0;
         done_seen_reg <= 1'b0;
         done          <= 1'b0;
         err_count     <= 8'h00;
      end else if (clk_en) begin
         done_s1_reg   <= done_tgl_reg;
         done_s2_reg   <= done_s1_reg;
         done_seen_reg <= done_s2_reg;
         done          <= (done_s2_reg != done_seen_reg);
         if (done_s2_reg != done_seen_reg)
            err_count <= l_err_reg;
      end
   end

   // ---------------- link side ----------------
   stf_pkg::stf_state_t state_reg;
   logic [15:0] cnt_reg;
   logic [15:0] crc_reg;
   logic [7:0]  sec_reg;
   logic [7:0]  pre_len_reg;
   logic [7:0]  gap_len_reg;
   logic        addr_bad_reg;
   logic        start;
   logic [7:0]  addr_b;

   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         req_s1_reg   <= 1'b0;
         req_s2_reg   <= 1'b0;
         req_seen_reg <= 1'b0;
      end else if (clk_en) begin
         req_s1_reg   <= req_tgl_reg;
         req_s2_reg   <= req_s1_reg;
         req_seen_reg <= req_s2_reg;
      end
   end
   assign start = (req_s2_reg != req_seen_reg);

   always_comb begin
      unique case (cnt_reg[2:0])
         3'h0:    addr_b = c_cyl_reg[15:8];
         3'h1:    addr_b = c_cyl_reg[7:0];
         3'h2:    addr_b = c_head_reg;
         3'h3:    addr_b = sec_reg;
         default: addr_b = c_flags_reg;
      endcase
   end

   // format and verify sequencer, one byte per link clock
   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         state_reg      <= stf_pkg::ST_IDLE;
         cnt_reg        <= 16'h0000;
         crc_reg        <= `STF_CRC_SEED;
         sec_reg        <= 8'h00;
         pre_len_reg    <= 8'(`STF_PRE_MIN);
         gap_len_reg    <= 8'(`STF_GAP_MIN);
         addr_bad_reg   <= 1'b0;
         l_err_reg      <= 8'h00;
         done_tgl_reg   <= 1'b0;
         lnk.drive_sel  <= 3'h0;
         lnk.cfg_req    <= 1'b0;
         lnk.write_gate <= 1'b0;
         lnk.read_gate  <= 1'b0;
         lnk.wr_byte    <= 8'h00;
      end else if (clk_en) begin
         cnt_reg     <= cnt_reg + 16'h0001;
         lnk.wr_byte <= `STF_PAD_BYTE;
         if (state_reg != stf_pkg::ST_IDLE && state_reg != stf_pkg::ST_CFG &&
             state_reg != stf_pkg::ST_WAIT_IDX && lnk.sector_pulse) begin
            lnk.write_gate <= 1'b0;
            lnk.read_gate  <= 1'b0;
            cnt_reg        <= 16'h0000;
            if (state_reg == stf_pkg::ST_RSYNC || state_reg == stf_pkg::ST_RADDR || addr_bad_reg)
               l_err_reg <= l_err_reg + 8'h01;
            addr_bad_reg <= 1'b0;
            if (sec_reg == 8'(SECTORS - 1)) begin
               state_reg     <= stf_pkg::ST_IDLE;
               lnk.drive_sel <= 3'h0;
               done_tgl_reg  <= !done_tgl_reg;
            end else begin
               sec_reg   <= sec_reg + 8'h01;
               state_reg <= stf_pkg::ST_GAP;
            end
         end else begin
            unique case (state_reg)
               stf_pkg::ST_IDLE: if (start) begin
                  lnk.drive_sel <= c_drive_reg;
                  lnk.cfg_req   <= 1'b1;
                  l_err_reg     <= 8'h00;
                  addr_bad_reg  <= 1'b0;
                  state_reg     <= stf_pkg::ST_CFG;
               end
               stf_pkg::ST_CFG: if (lnk.cfg_ack) begin
                  // sizes from drive; preamble floor at eleven, gap floor at sixteen
                  lnk.cfg_req <= 1'b0;
                  pre_len_reg <= (lnk.cfg_pre < 8'(`STF_PRE_MIN)) ? 8'(`STF_PRE_MIN) : lnk.cfg_pre;
                  gap_len_reg <= (lnk.cfg_gap < 8'(`STF_GAP_MIN)) ? 8'(`STF_GAP_MIN) : lnk.cfg_gap;
                  state_reg   <= stf_pkg::ST_WAIT_IDX;
               end
               stf_pkg::ST_WAIT_IDX: if (lnk.index_pulse) begin
                  sec_reg   <= 8'h00;
                  cnt_reg   <= 16'h0000;
                  state_reg <= stf_pkg::ST_GAP;
               end
               stf_pkg::ST_GAP: if (cnt_reg == 16'(gap_len_reg) - 16'(`STF_GAP_MIN - `STF_GAP_AFTER_IDX) - 16'h0001) begin
                  // gap after pulse, the rest of it trails the sector
                  cnt_reg <= 16'h0000;
                  crc_reg <= `STF_CRC_SEED;
                  if (c_verify_reg) begin
                     lnk.read_gate <= 1'b1;
                     state_reg     <= stf_pkg::ST_RSYNC;
                  end else begin
                     lnk.write_gate <= 1'b1;
                     state_reg      <= stf_pkg::ST_PRE;
                  end
               end
               // address area in order; zero preamble
               stf_pkg::ST_PRE: if (cnt_reg == 16'(pre_len_reg) - 16'h0001) begin
                  lnk.wr_byte <= `STF_SYNC_BYTE;
                  crc_reg     <= stf_pkg::stf_crc_step(`STF_CRC_SEED, `STF_SYNC_BYTE);
                  state_reg   <= stf_pkg::ST_SYNC;
               end
               stf_pkg::ST_SYNC: begin
                  cnt_reg     <= 16'h0000;
                  lnk.wr_byte <= c_cyl_reg[15:8];
                  crc_reg     <= stf_pkg::stf_crc_step(crc_reg, c_cyl_reg[15:8]);
                  state_reg   <= stf_pkg::ST_ADDR;
               end
               stf_pkg::ST_ADDR: begin
                  if (cnt_reg == 16'(`STF_ADDR_BYTES - 1)) begin
                     cnt_reg     <= 16'h0000;
                     lnk.wr_byte <= crc_reg[15:8];
                     state_reg   <= stf_pkg::ST_ACHK;
                  end else begin
                     lnk.wr_byte <= (cnt_reg == 16'h0000) ? c_cyl_reg[7:0] : (cnt_reg == 16'h0001) ? c_head_reg :
                                    (cnt_reg == 16'h0002) ? sec_reg : c_flags_reg;
                     crc_reg     <= stf_pkg::stf_crc_step(crc_reg, (cnt_reg == 16'h0000) ? c_cyl_reg[7:0] :
                                    (cnt_reg == 16'h0001) ? c_head_reg : (cnt_reg == 16'h0002) ? sec_reg : c_flags_reg);
                  end
               end
               stf_pkg::ST_ACHK: if (cnt_reg == 16'h0000) begin
                  lnk.wr_byte <= crc_reg[7:0];
               end else begin
                  cnt_reg   <= 16'h0000;
                  state_reg <= stf_pkg::ST_APAD;
               end
               stf_pkg::ST_APAD: if (cnt_reg == 16'(`STF_PAD_MIN - 1)) begin
                  // zero splice; gate stays on, drive turn-on fell in the address preamble
                  cnt_reg   <= 16'h0000;
                  state_reg <= stf_pkg::ST_SPLICE;
               end
               stf_pkg::ST_SPLICE: if (cnt_reg == 16'(`STF_SPLICE_MIN - 1)) begin
                  cnt_reg   <= 16'h0000;
                  state_reg <= stf_pkg::ST_DPRE;
               end
               stf_pkg::ST_DPRE: if (cnt_reg == 16'(pre_len_reg) - 16'h0001) begin
                  lnk.wr_byte <= `STF_SYNC_BYTE;
                  crc_reg     <= stf_pkg::stf_crc_step(`STF_CRC_SEED, `STF_SYNC_BYTE);
                  state_reg   <= stf_pkg::ST_DSYNC;
               end
               stf_pkg::ST_DSYNC: begin
                  cnt_reg     <= 16'h0000;
                  lnk.wr_byte <= c_fill_reg;
                  crc_reg     <= stf_pkg::stf_crc_step(crc_reg, c_fill_reg);
                  state_reg   <= stf_pkg::ST_DATA;
               end
               stf_pkg::ST_DATA: if (cnt_reg == 16'(DATA_BYTES - 1)) begin
                  cnt_reg     <= 16'h0000;
                  lnk.wr_byte <= crc_reg[15:8];
                  state_reg   <= stf_pkg::ST_DCHK;
               end else begin
                  lnk.wr_byte <= c_fill_reg;
                  crc_reg     <= stf_pkg::stf_crc_step(crc_reg, c_fill_reg);
               end
               stf_pkg::ST_DCHK: if (cnt_reg == 16'h0000) begin
                  lnk.wr_byte <= crc_reg[7:0];
               end else begin
                  cnt_reg   <= 16'h0000;
                  state_reg <= stf_pkg::ST_DPAD;
               end
               stf_pkg::ST_DPAD: if (cnt_reg == 16'(`STF_PAD_MIN - 1)) begin
                  cnt_reg   <= 16'h0000;
                  state_reg <= stf_pkg::ST_HOLD;
               end
               stf_pkg::ST_HOLD: if (cnt_reg == 16'(`STF_WG_HOLD - 1)) begin
                  lnk.write_gate <= 1'b0;
                  state_reg      <= stf_pkg::ST_NEXT;
               end
               // hunt sync, then check the address
               stf_pkg::ST_RSYNC: if (lnk.rd_valid && lnk.rd_byte == `STF_SYNC_BYTE) begin
                  cnt_reg   <= 16'h0000;
                  crc_reg   <= stf_pkg::stf_crc_step(`STF_CRC_SEED, `STF_SYNC_BYTE);
                  state_reg <= stf_pkg::ST_RADDR;
               end
               stf_pkg::ST_RADDR: if (!lnk.rd_valid) begin
                  cnt_reg <= cnt_reg;
               end else begin
                  crc_reg <= stf_pkg::stf_crc_step(crc_reg, lnk.rd_byte);
                  if (cnt_reg < 16'(`STF_ADDR_BYTES) && lnk.rd_byte != addr_b)
                     addr_bad_reg <= 1'b1;
                  if (cnt_reg == 16'(`STF_ADDR_BYTES + `STF_CHK_BYTES - 1)) begin
                     // residue of zero means the check bytes agree
                     if (stf_pkg::stf_crc_step(crc_reg, lnk.rd_byte) != 16'h0000)
                        addr_bad_reg <= 1'b1;
                     lnk.read_gate <= 1'b0;
                     state_reg     <= stf_pkg::ST_NEXT;
                  end
               end
               // waits for the next sector pulse, handled above
               stf_pkg::ST_NEXT: cnt_reg <= cnt_reg;
            endcase
         end
      end
   end

endmodule : stf_ctrl

// [hw/stf_defs.svh]
// timing counts, field sizes and patterns of the sector track format framer
`ifndef STF_DEFS_SVH
`define STF_DEFS_SVH

`define STF_GAP_MIN        16         // intersector gap, bytes
`define STF_GAP_AFTER_IDX  12         // part of the gap that follows a sector pulse
`define STF_PRE_MIN        11         // clock lock preamble, bytes
`define STF_SYNC_BYTE      8'hFE      // byte sync pattern
`define STF_ADDR_BYTES     5          // cylinder hi, cylinder lo, head, sector, flags
`define STF_CHK_BYTES      2          // check bytes after address and data
`define STF_PAD_MIN        2          // trailer pad, bytes
`define STF_SPLICE_MIN     1          // write splice, bytes
`define STF_WG_HOLD        2          // write gate hold after last byte, byte times
`define STF_REF_PER_BYTE   8          // reference clock periods in one byte time
`define STF_TURNON_MIN     3          // write driver turn-on, reference periods
`define STF_TURNON_MAX     7
`define STF_TURNON_BYTES   ((`STF_TURNON_MAX + `STF_REF_PER_BYTE - 1) / `STF_REF_PER_BYTE)
`define STF_DATA_BYTES     512        // data field length
`define STF_SECT_BYTES     595        // unformatted bytes per sector
`define STF_SECTORS        35         // sectors per track
`define STF_MAX_DRIVES     7          // drives on one controller
`define STF_CRC_POLY       16'h1021
`define STF_CRC_SEED       16'h0000
`define STF_PAD_BYTE       8'h00

`endif

// [hw/stf_drive.sv]
// drive end: rotation-locked index and sector pulses, configuration answer, write path
`include "stf_defs.svh"
module stf_drive #(
   parameter int          SECT_BYTES = `STF_SECT_BYTES,
   parameter int          SECTORS    = `STF_SECTORS,
   parameter logic [2:0]  DRIVE_ADDR = 3'h1,
   parameter logic [7:0]  PRE_BYTES  = 8'(`STF_PRE_MIN),
   parameter logic [7:0]  GAP_BYTES  = 8'(`STF_GAP_MIN)
) (
   stf_link_if.drive      lnk,        // link to the controller
   input  wire logic      rst,        // async reset, active high
   input  wire logic      clk_en,     // freezes all state while low
   input  wire logic [7:0] play_byte, // byte coming off the medium
   input  wire logic      play_valid, // play_byte holds a byte
   output logic [7:0]     rec_byte,   // byte going onto the medium
   output logic           rec_valid,  // rec_byte is being recorded
   output logic           selected    // this drive is addressed
);
   // refuse an address outside the chain or a sector below the floor
   if (DRIVE_ADDR == 3'h0 || DRIVE_ADDR > 3'(`STF_MAX_DRIVES) || SECTORS < 1 || SECT_BYTES < 82) begin : g_bad_params
      $error("stf_drive: bad parameters");
   end

   localparam int TURNON = `STF_TURNON_BYTES;

   logic [15:0] byte_cnt_reg;
   logic [15:0] sec_cnt_reg;
   logic [TURNON-1:0] wg_dly_reg;
   logic        track_start;
   logic        sector_start;

   assign selected     = (lnk.drive_sel == DRIVE_ADDR);
   assign track_start  = (byte_cnt_reg == 16'h0000) && (sec_cnt_reg == 16'h0000);
   assign sector_start = (byte_cnt_reg == 16'h0000);

   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         byte_cnt_reg <= 16'h0000;
         sec_cnt_reg  <= 16'h0000;
      end else if (clk_en) begin
         if (byte_cnt_reg == 16'(SECT_BYTES - 1)) begin
            byte_cnt_reg <= 16'h0000;
            sec_cnt_reg  <= (sec_cnt_reg == 16'(SECTORS - 1)) ? 16'h0000 : sec_cnt_reg + 16'h0001;
         end else begin
            byte_cnt_reg <= byte_cnt_reg + 16'h0001;
         end
      end
   end

   // index and sector pulses; a deselected drive leaves the chain quiet
   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         lnk.index_pulse  <= 1'b0;
         lnk.sector_pulse <= 1'b0;
      end else if (clk_en) begin
         lnk.index_pulse  <= selected && track_start;
         lnk.sector_pulse <= selected && sector_start;
      end
   end

   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         lnk.cfg_ack <= 1'b0;
         lnk.cfg_pre <= 8'h00;
         lnk.cfg_gap <= 8'h00;
      end else if (clk_en) begin
         lnk.cfg_ack <= selected && lnk.cfg_req;
         lnk.cfg_pre <= PRE_BYTES;
         lnk.cfg_gap <= GAP_BYTES;
      end
   end

   // write driver turn-on delay, which drops the first address preamble bytes
   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         wg_dly_reg <= '0;
         rec_byte   <= 8'h00;
         rec_valid  <= 1'b0;
      end else if (clk_en) begin
         wg_dly_reg <= TURNON'({wg_dly_reg, selected && lnk.write_gate});
         rec_valid  <= wg_dly_reg[TURNON-1] && selected && lnk.write_gate;
         rec_byte   <= lnk.wr_byte;
      end
   end

   // read path, data lines are radial so no sharing beyond the select
   always_ff @(posedge lnk.link_clk or posedge rst) begin
      if (rst) begin
         lnk.rd_byte  <= 8'h00;
         lnk.rd_valid <= 1'b0;
      end else if (clk_en) begin
         lnk.rd_byte  <= play_byte;
         lnk.rd_valid <= selected && lnk.read_gate && !lnk.write_gate && play_valid;
      end
   end

endmodule : stf_drive

// [hw/stf_link_if.sv]
// link between the drive end and the controller end of the framer
`include "stf_defs.svh"
interface stf_link_if;
   logic            link_clk;     // byte clock from outside, an input at both ends, locked to rotation
   logic            index_pulse;  // one byte time at track start
   logic            sector_pulse; // one byte time at each sector start
   logic [2:0]      drive_sel;    // shared select, 0 selects no drive
   logic            cfg_req;      // configuration request
   logic            cfg_ack;      // configuration answer valid
   logic [7:0]      cfg_pre;      // required preamble bytes
   logic [7:0]      cfg_gap;      // required intersector gap bytes
   logic            write_gate;   // controller is writing
   logic [7:0]      wr_byte;      // byte to record
   logic            read_gate;    // controller is reading
   logic [7:0]      rd_byte;      // byte read back
   logic            rd_valid;     // rd_byte holds a byte

   modport drive (input link_clk, drive_sel, cfg_req, write_gate, wr_byte, read_gate,
                  output index_pulse, sector_pulse, cfg_ack, cfg_pre, cfg_gap, rd_byte, rd_valid);
   modport ctrl  (input link_clk, index_pulse, sector_pulse, cfg_ack, cfg_pre, cfg_gap, rd_byte, rd_valid,
                  output drive_sel, cfg_req, write_gate, wr_byte, read_gate);
endinterface : stf_link_if

// [hw/stf_pkg.sv]
// types and the check code used by the controller end of the framer
`include "stf_defs.svh"
package stf_pkg;

   typedef enum logic [4:0] {
      ST_IDLE, ST_CFG, ST_WAIT_IDX, ST_GAP, ST_PRE, ST_SYNC, ST_ADDR, ST_ACHK, ST_APAD,
      ST_SPLICE, ST_DPRE, ST_DSYNC, ST_DATA, ST_DCHK, ST_DPAD, ST_HOLD, ST_RSYNC, ST_RADDR, ST_NEXT
   } stf_state_t;

   typedef logic [7:0] stf_byte_t;

   // one byte through the msb-first check polynomial
   function automatic logic [15:0] stf_crc_step(input logic [15:0] crc, input logic [7:0] din);
      logic [15:0] c;
      c = crc ^ {din, 8'h00};
      for (int i = 0; i < 8; i++) begin
         c = c[15] ? ((c << 1) ^ `STF_CRC_POLY) : (c << 1);
      end
      return c;
   endfunction : stf_crc_step

endpackage : stf_pkg

// [tb/sector_track_format_framer_test.sv]
// bench: format one track, check the byte stream, then verify a blank track
module sector_track_format_framer_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, rst, clk_en, cmd_valid, cmd_verify, cmd_ready, done, play_valid, rec_valid, selected, k;
   logic [7:0]  err_count, rec_byte, e, play_byte = 8'h00, cmd_head = 8'h05, cmd_flags = 8'hA5, cmd_fill = 8'h3C;
   logic [2:0]  cmd_drive = 3'h1;
   logic [15:0] cmd_cyl = 16'h1234, crc;
   int          bad_count, checked, gpos, since, snum, nsec, tpos;
   logic [7:0]  track [164] = '{default: 8'h00};
   logic        replay = 1'b0;
   stf_link_if lnk();
   stf_drive #(.SECT_BYTES(82), .SECTORS(2)) stf_drive_i (.lnk, .rst, .clk_en, .play_byte, .play_valid,
      .rec_byte, .rec_valid, .selected);
   stf_ctrl #(.SECTORS(2), .DATA_BYTES(16)) stf_ctrl_i (.lnk, .core_clk, .rst, .clk_en, .cmd_valid, .cmd_ready,
      .cmd_verify, .cmd_drive, .cmd_cyl, .cmd_head, .cmd_flags, .cmd_fill, .done, .err_count);
   stf_assertions #(.SECT_BYTES(82)) stf_assertions_i (.link_clk(lnk.link_clk), .rst(rst),
      .index_pulse(lnk.index_pulse), .sector_pulse(lnk.sector_pulse), .drive_sel(lnk.drive_sel),
      .cfg_req(lnk.cfg_req), .cfg_ack(lnk.cfg_ack), .write_gate(lnk.write_gate), .wr_byte(lnk.wr_byte));
   // two unrelated clocks
   initial begin core_clk = 0; forever #2.5 core_clk = ~core_clk; end
   initial begin lnk.link_clk = 0; #37; forever #62.5 lnk.link_clk = ~lnk.link_clk; end
   task automatic chk(string what, logic [15:0] ex, logic [15:0] s);
      checked++;
      if (s !== ex) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, ex, s);
      end
   endtask : chk
   // own check code, independent of the design's
   function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
      c ^= {d, 8'h00};
      for (int i = 0; i < 8; i++) c = c[15] ? (c << 1) ^ 16'h1021 : c << 1;
      return c;
   endfunction : crc_byte
   task automatic wrap_up;
      $display("checked %0d bad %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // one command, bounded wait for done; busy must refuse right after take
   task automatic run_cmd(logic v);
      @(posedge core_clk);
      #1 cmd_valid = 1;
      cmd_verify = v;
      @(posedge core_clk);
      #1 cmd_valid = 0;
      chk("cmd_ready", 0, cmd_ready);
      for (int i = 0; i < 40000 && done !== 1'b1; i++) @(posedge core_clk) #1;
      chk("done", 1, done);
   endtask : run_cmd
   task automatic t_format;
      int n0 = nsec;
      run_cmd(0);
      chk("sectors", 2, 16'(nsec - n0));
      chk("err_count", 0, err_count);
      $display("test format finished");
   endtask : t_format
   // read back the formatted track: every address must check clean
   task automatic t_replay;
      replay = 1;
      run_cmd(1);
      replay = 0;
      chk("err_count", 0, err_count);
      $display("test replay finished");
   endtask : t_replay
   // blank medium: every address read must fail
   task automatic t_verify;
      run_cmd(1);
      chk("err_count", 2, err_count);
      $display("test verify finished");
   endtask : t_verify
   // medium: keep what the drive records, play it back by rotation position
   always @(posedge lnk.link_clk) begin
      tpos = lnk.index_pulse ? 0 : (tpos + 1) % 164;
      if (rec_valid) track[tpos] = rec_byte;
      #1 play_byte = track[tpos];
      play_valid = replay;
   end
   // wire monitor: byte position inside each written sector
   always @(posedge lnk.link_clk) begin
      if (lnk.sector_pulse) snum = lnk.index_pulse ? 0 : snum + 1;
      since = lnk.sector_pulse ? 0 : since + 1;
      if (lnk.write_gate) begin
         if (gpos == 0) chk("gap", 1, since >= 12);
         if (gpos == 0) chk("selected", 1, selected);
         if (gpos == 1) chk("rec_valid_off", 0, rec_valid);
         if (gpos == 4) chk("rec_valid", 1, rec_valid);
         e = 8'h00;
         k = 1;
         case (gpos)
            11, 33: e = 8'hFE;
            12: e = cmd_cyl[15:8];
            13: e = cmd_cyl[7:0];
            14: e = cmd_head;
            15: e = snum[7:0];
            16: e = cmd_flags;
            17, 18, 50, 51, 54, 55: k = 0;
            default: if (gpos > 33 && gpos < 50) e = cmd_fill;
         endcase
         if (k) chk("wr_byte", e, lnk.wr_byte);
         if ((gpos >= 11 && gpos <= 18) || (gpos >= 33 && gpos <= 51))
            crc = crc_byte((gpos == 11 || gpos == 33) ? 16'h0000 : crc, lnk.wr_byte);
         if (gpos == 19 || gpos == 52) chk("crc", 0, crc);
         gpos++;
      end else if (gpos != 0) begin
         chk("gate_len", 56, gpos[15:0]);
         nsec++;
         gpos = 0;
      end
   end
   // watchdog, well beyond three commands of two rotations each
   initial begin
      #300000;
      bad_count++;
      wrap_up();
   end
   initial begin
      rst = 1;
      clk_en = 1;
      cmd_valid = 0;
      cmd_verify = 0;
      repeat (4) @(posedge core_clk);
      repeat (2) @(posedge lnk.link_clk);
      #1 rst = 0;
      t_format();
      t_replay();
      t_verify();
      wrap_up();
   end
endmodule : sector_track_format_framer_test

// [tb/stf_assertions.sv]
// link-side property checks of the framer, link clock domain only
module stf_assertions #(
   parameter int SECT_BYTES = 82
) (
   input wire logic       link_clk,     // byte clock
   input wire logic       rst,          // async reset
   input wire logic       index_pulse,  // track start
   input wire logic       sector_pulse, // sector start
   input wire logic [2:0] drive_sel,    // drive address
   input wire logic       cfg_req,      // config request
   input wire logic       cfg_ack,      // config answer
   input wire logic       write_gate,   // writing
   input wire logic [7:0] wr_byte       // byte written
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (rst);
   // pulses are one byte wide and rotation locked
   AST_PULSE_ONE: assert property (sector_pulse |=> !sector_pulse) else $error("sector pulse too wide");
   AST_INDEX_SECT: assert property (index_pulse |-> sector_pulse) else $error("index without sector");
   // a drive deselected at the end of a track goes quiet, which is not a period fault
   AST_PERIOD: assert property (sector_pulse |-> ##SECT_BYTES (sector_pulse || drive_sel == 3'h0)) else $error("sector period");
   // gap after the pulse, then preamble and sync
   AST_GAP: assert property (sector_pulse |=> !write_gate [*8]) else $error("gap too short");
   AST_PRE: assert property ($rose(write_gate) |-> wr_byte == 8'h00 [*8]) else $error("preamble not zero");
   AST_SYNC: assert property ($rose(write_gate) |-> ##11 wr_byte == 8'hFE) else $error("sync missing");
   AST_HOLD: assert property ($fell(write_gate) |-> $past(write_gate, 3)) else $error("gate hold short");
   AST_CFG: assert property (cfg_req && drive_sel == 3'h1 |=> cfg_ack) else $error("no config answer");
   AST_SEL: assert property (cfg_req |-> drive_sel != 3'h0) else $error("request unselected");
   COV_CFG: cover property (cfg_ack);
   COV_WRITE: cover property ($rose(write_gate));
   COV_INDEX: cover property (index_pulse);
endmodule : stf_assertions
